// ### sap_pkg.sv
/*
 * sap_pkg: constants shared by the serial command interpreter.
 * Assumes a 100 MHz pclk. Long counts are also top-level parameters.
 */
package sap_pkg;
	// ---------------------------------------------------------------
	// clock and timing
	// ---------------------------------------------------------------
	localparam int unsigned CLK_HZ          = 100000000;
	localparam int unsigned GUARD_MS        = 'h3e8;
	localparam int unsigned GUARD_CYC       = GUARD_MS * (CLK_HZ / 1000);
	localparam int unsigned TIMEOUT_MS      = 10000;
	localparam int unsigned TIMEOUT_CYC     = TIMEOUT_MS * (CLK_HZ / 1000);
	localparam int unsigned RST_DELAY_MS    = 100;
	localparam int unsigned RST_DELAY_CYC   = RST_DELAY_MS * (CLK_HZ / 1000);

	// ---------------------------------------------------------------
	// characters
	// ---------------------------------------------------------------
	localparam logic [7:0] CHR_CR    = 8'h0d;
	localparam logic [7:0] CHR_COMMA = 8'h2c;
	localparam logic [7:0] CHR_A     = 8'h41;
	localparam logic [7:0] CHR_T     = 8'h54;
	localparam logic [7:0] CHR_O     = 8'h4f;
	localparam logic [7:0] CHR_K     = 8'h4b;
	localparam logic [7:0] CHR_E     = 8'h45;
	localparam logic [7:0] CHR_R     = 8'h52;
	localparam logic [7:0] ESC_RST   = 8'h2b;

	// ---------------------------------------------------------------
	// two-letter command codes
	// ---------------------------------------------------------------
	localparam logic [15:0] CMD_LANE  = 16'h4348;
	localparam logic [15:0] CMD_PAN   = 16'h4944;
	localparam logic [15:0] CMD_DHI   = 16'h4448;
	localparam logic [15:0] CMD_DLO   = 16'h444c;
	localparam logic [15:0] CMD_SAVE  = 16'h5752;
	localparam logic [15:0] CMD_DFLT  = 16'h5245;
	localparam logic [15:0] CMD_SRST  = 16'h4652;
	localparam logic [15:0] CMD_LEAVE = 16'h434e;

	// ---------------------------------------------------------------
	// parameter limits and factory defaults
	// ---------------------------------------------------------------
	localparam logic [7:0]  LANE_MIN  = 8'h0c;
	localparam logic [7:0]  LANE_MAX  = 8'h17;
	localparam logic [7:0]  LANE_RST  = 8'h0c;
	localparam logic [15:0] PAN_RST   = 16'h3332;
	localparam logic [15:0] PAN_ALL   = 16'hffff;
	localparam logic [31:0] DEST_RST  = 32'h0000_0000;
	localparam logic [31:0] SHORT_LIM = 32'h0000_ffff;

	// ---------------------------------------------------------------
	// apb register offsets and status bits
	// ---------------------------------------------------------------
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_ESC    = 8'h04;
	localparam logic [7:0] REG_LANPAN = 8'h08;
	localparam logic [7:0] REG_DHI    = 8'h0c;
	localparam logic [7:0] REG_DLO    = 8'h10;
	localparam int unsigned ST_B_CMD   = 0;
	localparam int unsigned ST_B_SHORT = 1;
	localparam int unsigned ST_B_BCAST = 2;
	localparam int unsigned ST_B_ALLPN = 3;
	localparam int unsigned ST_B_RSTPD = 4;

	typedef enum logic [2:0] {
		ST_DATA  = 3'b000,
		ST_ESCG  = 3'b001,
		ST_PRE_A = 3'b010,
		ST_PRE_T = 3'b011,
		ST_NAME0 = 3'b100,
		ST_NAME1 = 3'b101,
		ST_VALUE = 3'b110,
		ST_REPLY = 3'b111
	} sap_state_t;
endpackage

// ### sap_parser.sv
/*
 * sap_parser: text command interpreter on the modem's serial host port.
 * Assumes a UART on pclk delivering rx bytes and accepting tx bytes,
 * and an APB master for the side registers.
 */
// The register addresses and register access over APB are this design's own decisions.
// Overview of operation
// RL1 - three escape characters enter command mode; reply OK and CR
// RL2 - empty parameter field reads; reply value in hex then CR
// RL3 - command with a value writes the parameter; reply OK and CR
// RL4 - comma-separated commands run in order, one reply each
// RL5 - leave command replies OK then returns to data mode
// RL6 - parameter values are parsed as hexadecimal digits
// RL7 - save copies working parameters into the retained store
// RL8 - host sends nothing after save until its OK has arrived
// RL9 - defaults command reloads every parameter with factory values
// RL10 - soft reset replies OK then hard resets about 100 ms later
// RL11 - lane number accepted 12 to 23 only, resets to 12
// RL12 - 16-bit pan tag defaults 0x3332; all ones means every network
// RL13 - destination is upper word over lower word, both reset zero
// RL14 - upper zero and lower below 0xffff selects short addressing
// RL15 - destination equal to 0xffff is a network broadcast
// RL16 - escape needs guard idle, three chars within guard, guard idle
// RL17 - no valid command within the timeout leaves command mode; here any received byte restarts the timer
// RL18 - a failing command replies ERROR instead of OK
// RL19 - line starts with AT and ends in CR; after comma no prefix
// RL20 - out-of-range value gives ERROR and keeps the stored value
`timescale 1ns/10ps
`default_nettype none
module sap_parser #(
	parameter logic [31:0] GUARD_CYCLES   = sap_pkg::GUARD_CYC,
	parameter logic [31:0] TIMEOUT_CYCLES = sap_pkg::TIMEOUT_CYC,
	parameter logic [31:0] RESET_CYCLES   = sap_pkg::RST_DELAY_CYC
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// serial bytes from and to the host
	input  wire logic        rx_valid,
	input  wire logic [7:0]  rx_data,
	output logic             tx_valid,
	output logic [7:0]       tx_data,
	input  wire logic        tx_ready,
	// configuration towards the radio
	output logic [7:0]       radio_lane_number,
	output logic [15:0]      pan_tag,
	output logic [63:0]      dest_addr,
	output logic             short_addr_mode,
	output logic             dest_broadcast,
	output logic             pan_broadcast,
	output logic             command_mode,
	output logic             hard_reset
);
	// ---------------------------------------------------------------
	// functions
	// ---------------------------------------------------------------
	// returns {valid, nibble} for an ascii hex digit
	function automatic logic [4:0] hex_val(input logic [7:0] c);
		if (c >= 8'h30 && c <= 8'h39) begin
			hex_val = {1'b1, c[3:0]};
		end else if ((c >= 8'h41 && c <= 8'h46) ||
		             (c >= 8'h61 && c <= 8'h66)) begin
			hex_val = {1'b1, c[3:0] + 4'h9};
		end else begin
			hex_val = 5'h00;
		end
	endfunction

	function automatic logic [7:0] hex_chr(input logic [3:0] n);
		hex_chr = (n < 4'ha) ? {4'h3, n} : {4'h4, n - 4'h9};
	endfunction

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	sap_pkg::sap_state_t st_ff, follow_ff;
	logic [31:0] idle_cnt_ff, seq_cnt_ff, cmd_cnt_ff, rst_cnt_ff;
	logic [1:0]  plus_cnt_ff;
	logic [7:0]  name0_ff, name1_ff, esc_ff;
	logic [31:0] val_ff;
	logic [3:0]  ndig_ff;
	logic        bad_ff, rst_pend_ff;
	logic [7:0]  lane_ff, nv_lane_ff;
	logic [15:0] pan_ff, nv_pan_ff;
	logic [31:0] dhi_ff, dlo_ff, nv_dhi_ff, nv_dlo_ff;
	logic [7:0]  rbuf_ff [0:8];
	logic [3:0]  rlen_ff, ridx_ff;

	// ---------------------------------------------------------------
	// command decode and execution checks
	// ---------------------------------------------------------------
	logic [15:0] cmd;
	logic        has_val, delim, exec_err, is_read, is_param;
	logic [31:0] rd_val;
	logic [3:0]  nd;
	logic [4:0]  hv;
	logic        esc_ok, load_ok, load_err, load_rd, reply_done;
	logic        cmd_tmo, esc_hit;

	assign cmd     = {name0_ff, name1_ff};
	assign has_val = (ndig_ff != 4'h0);
	assign delim   = rx_valid && (st_ff == sap_pkg::ST_VALUE) &&
	                 (rx_data == sap_pkg::CHR_CR ||
	                  rx_data == sap_pkg::CHR_COMMA);
	assign hv      = hex_val(rx_data);

	always_comb begin
		exec_err = bad_ff; // [RL6]
		is_param = 1'b1;
		rd_val   = 32'h0;
		case (cmd)
			sap_pkg::CMD_LANE: begin
				rd_val = {24'h0, lane_ff};
				if (has_val && (val_ff < {24'h0, sap_pkg::LANE_MIN} ||
				    val_ff > {24'h0, sap_pkg::LANE_MAX})) begin
					exec_err = 1'b1; // [RL11] [RL20]
				end
			end
			sap_pkg::CMD_PAN: begin
				rd_val = {16'h0, pan_ff};
				if (has_val && val_ff[31:16] != 16'h0) begin
					exec_err = 1'b1; // [RL20]
				end
			end
			sap_pkg::CMD_DHI: rd_val = dhi_ff;
			sap_pkg::CMD_DLO: rd_val = dlo_ff;
			sap_pkg::CMD_SAVE, sap_pkg::CMD_DFLT,
			sap_pkg::CMD_SRST, sap_pkg::CMD_LEAVE: begin
				is_param = 1'b0;
				exec_err = exec_err | has_val;
			end
			default: begin
				is_param = 1'b0;
				exec_err = 1'b1; // [RL18]
			end
		endcase
		is_read = is_param && !has_val && !exec_err; // [RL2]
	end

	// significant hex digits of a read value, at least one
	always_comb begin
		nd = 4'h1;
		for (int i = 1; i < 8; i++) begin
			if (rd_val[4*i +: 4] != 4'h0) begin
				nd = 4'(i + 1);
			end
		end
	end

	assign esc_hit    = rx_valid && (rx_data == esc_ff) &&
	                    ((plus_cnt_ff == 2'd0) ?
	                     (idle_cnt_ff >= GUARD_CYCLES) :
	                     (seq_cnt_ff < GUARD_CYCLES)); // [RL16]
	assign esc_ok     = (st_ff == sap_pkg::ST_ESCG) && !rx_valid &&
	                    (idle_cnt_ff >= GUARD_CYCLES); // [RL16]
	assign load_rd    = delim && is_read;
	assign load_err   = delim && exec_err;
	assign load_ok    = esc_ok || (delim && !exec_err && !is_read);
	assign reply_done = (st_ff == sap_pkg::ST_REPLY) &&
	                    (ridx_ff == rlen_ff) && (!tx_valid || tx_ready);
	assign cmd_tmo    = (st_ff >= sap_pkg::ST_PRE_A) &&
	                    (st_ff != sap_pkg::ST_REPLY) && !rst_pend_ff &&
	                    (cmd_cnt_ff >= TIMEOUT_CYCLES);

	// ---------------------------------------------------------------
	// timers
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_cnt_ff <= 32'h0;
			seq_cnt_ff  <= 32'h0;
			cmd_cnt_ff  <= 32'h0;
		end else begin
			idle_cnt_ff <= rx_valid ? 32'h0 :
			    (idle_cnt_ff < GUARD_CYCLES) ? idle_cnt_ff + 32'h1 :
			    idle_cnt_ff;
			seq_cnt_ff  <= (plus_cnt_ff == 2'd0) ? 32'h0 :
			    (seq_cnt_ff < GUARD_CYCLES) ? seq_cnt_ff + 32'h1 :
			    seq_cnt_ff;
			cmd_cnt_ff  <= (rx_valid || st_ff == sap_pkg::ST_REPLY) ?
			    32'h0 : cmd_cnt_ff + 32'h1; // [RL17]
		end
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff       <= sap_pkg::ST_DATA;
			follow_ff   <= sap_pkg::ST_DATA;
			plus_cnt_ff <= 2'd0;
			name0_ff    <= 8'h0;
			name1_ff    <= 8'h0;
			val_ff      <= 32'h0;
			ndig_ff     <= 4'h0;
			bad_ff      <= 1'b0;
		end else if (hard_reset || cmd_tmo) begin
			st_ff       <= sap_pkg::ST_DATA; // [RL17]
			plus_cnt_ff <= 2'd0;
		end else begin
			unique case (st_ff)
				sap_pkg::ST_DATA: begin
					if (rx_valid) begin
						plus_cnt_ff <= esc_hit ? plus_cnt_ff + 2'd1 : 2'd0;
						if (esc_hit && plus_cnt_ff == 2'd2) begin
							st_ff <= sap_pkg::ST_ESCG;
						end
					end else if (plus_cnt_ff != 2'd0 &&
					             seq_cnt_ff >= GUARD_CYCLES) begin
						plus_cnt_ff <= 2'd0;
					end
				end
				sap_pkg::ST_ESCG: begin
					plus_cnt_ff <= 2'd0;
					if (rx_valid) begin
						st_ff <= sap_pkg::ST_DATA;
					end else if (esc_ok) begin
						st_ff     <= sap_pkg::ST_REPLY; // [RL1]
						follow_ff <= sap_pkg::ST_PRE_A;
					end
				end
				sap_pkg::ST_PRE_A: begin
					if (rx_valid && (rx_data | 8'h20) == (sap_pkg::CHR_A | 8'h20)) begin
						st_ff <= sap_pkg::ST_PRE_T; // [RL19]
					end
				end
				sap_pkg::ST_PRE_T: begin
					if (rx_valid) begin
						st_ff <= ((rx_data | 8'h20) == (sap_pkg::CHR_T | 8'h20)) ?
						    sap_pkg::ST_NAME0 : sap_pkg::ST_PRE_A;
					end
				end
				sap_pkg::ST_NAME0: begin
					if (rx_valid) begin
						name0_ff <= rx_data & 8'hdf;
						val_ff   <= 32'h0;
						ndig_ff  <= 4'h0;
						bad_ff   <= 1'b0;
						st_ff    <= sap_pkg::ST_NAME1;
					end
				end
				sap_pkg::ST_NAME1: begin
					if (rx_valid) begin
						name1_ff <= rx_data & 8'hdf;
						st_ff    <= sap_pkg::ST_VALUE;
					end
				end
				sap_pkg::ST_VALUE: begin
					if (delim) begin
						st_ff     <= sap_pkg::ST_REPLY;
						follow_ff <= (rx_data == sap_pkg::CHR_COMMA) ?
						    sap_pkg::ST_NAME0 : sap_pkg::ST_PRE_A; // [RL4] [RL19]
						if (!exec_err && cmd == sap_pkg::CMD_LEAVE) begin
							follow_ff <= sap_pkg::ST_DATA; // [RL5]
						end
					end else if (rx_valid) begin
						if (!hv[4] || ndig_ff == 4'h8) begin
							bad_ff <= 1'b1; // [RL6]
						end else begin
							val_ff  <= {val_ff[27:0], hv[3:0]}; // [RL6]
							ndig_ff <= ndig_ff + 4'h1;
						end
					end
				end
				sap_pkg::ST_REPLY: begin
					if (reply_done && !rst_pend_ff) begin
						st_ff <= follow_ff;
					end
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// parameters, retained store and soft reset
	// ---------------------------------------------------------------
	logic do_wr;
	assign do_wr = delim && !exec_err && has_val; // [RL3]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lane_ff <= sap_pkg::LANE_RST; // [RL11]
			pan_ff  <= sap_pkg::PAN_RST;  // [RL12]
			dhi_ff  <= sap_pkg::DEST_RST; // [RL13]
			dlo_ff  <= sap_pkg::DEST_RST;
		end else if (hard_reset) begin
			lane_ff <= nv_lane_ff; // [RL7]
			pan_ff  <= nv_pan_ff;
			dhi_ff  <= nv_dhi_ff;
			dlo_ff  <= nv_dlo_ff;
		end else if (delim && !exec_err && cmd == sap_pkg::CMD_DFLT) begin
			lane_ff <= sap_pkg::LANE_RST; // [RL9]
			pan_ff  <= sap_pkg::PAN_RST;
			dhi_ff  <= sap_pkg::DEST_RST;
			dlo_ff  <= sap_pkg::DEST_RST;
		end else if (do_wr) begin
			unique case (cmd)
				sap_pkg::CMD_LANE: lane_ff <= val_ff[7:0]; // [RL11]
				sap_pkg::CMD_PAN:  pan_ff  <= val_ff[15:0]; // [RL12]
				sap_pkg::CMD_DHI:  dhi_ff  <= val_ff; // [RL13]
				sap_pkg::CMD_DLO:  dlo_ff  <= val_ff;
				default: ;
			endcase
		end
	end

	// retained store is only cleared by power-on reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nv_lane_ff <= sap_pkg::LANE_RST;
			nv_pan_ff  <= sap_pkg::PAN_RST;
			nv_dhi_ff  <= sap_pkg::DEST_RST;
			nv_dlo_ff  <= sap_pkg::DEST_RST;
		end else if (delim && !exec_err && cmd == sap_pkg::CMD_SAVE) begin
			nv_lane_ff <= lane_ff; // [RL7]
			nv_pan_ff  <= pan_ff;
			nv_dhi_ff  <= dhi_ff;
			nv_dlo_ff  <= dlo_ff;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_pend_ff <= 1'b0;
			rst_cnt_ff  <= 32'h0;
			hard_reset  <= 1'b0;
		end else begin
			hard_reset <= 1'b0;
			if (delim && !exec_err && cmd == sap_pkg::CMD_SRST) begin
				rst_pend_ff <= 1'b1; // [RL10]
				rst_cnt_ff  <= 32'h0;
			end else if (rst_pend_ff && !hard_reset) begin
				rst_cnt_ff <= rst_cnt_ff + 32'h1;
				if (rst_cnt_ff >= RESET_CYCLES - 32'h1) begin
					rst_pend_ff <= 1'b0;
					hard_reset  <= 1'b1; // [RL10]
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// reply buffer and transmit
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < 9; i++) begin
				rbuf_ff[i] <= 8'h0;
			end
			rlen_ff  <= 4'h0;
			ridx_ff  <= 4'h0;
			tx_valid <= 1'b0;
			tx_data  <= 8'h0;
		end else begin
			if (load_ok) begin
				rbuf_ff[0] <= sap_pkg::CHR_O; // [RL1] [RL3] [RL5]
				rbuf_ff[1] <= sap_pkg::CHR_K;
				rbuf_ff[2] <= sap_pkg::CHR_CR;
				rlen_ff    <= 4'h3;
				ridx_ff    <= 4'h0;
			end else if (load_err) begin
				rbuf_ff[0] <= sap_pkg::CHR_E; // [RL18] [RL20]
				rbuf_ff[1] <= sap_pkg::CHR_R;
				rbuf_ff[2] <= sap_pkg::CHR_R;
				rbuf_ff[3] <= sap_pkg::CHR_O;
				rbuf_ff[4] <= sap_pkg::CHR_R;
				rbuf_ff[5] <= sap_pkg::CHR_CR;
				rlen_ff    <= 4'h6;
				ridx_ff    <= 4'h0;
			end else if (load_rd) begin
				for (int i = 0; i < 8; i++) begin
					rbuf_ff[i] <= (4'(i) < nd) ?
					    hex_chr(rd_val[4*(nd - 4'h1 - 4'(i)) +: 4]) :
					    sap_pkg::CHR_CR; // [RL2]
				end
				rbuf_ff[8] <= sap_pkg::CHR_CR;
				rlen_ff    <= nd + 4'h1;
				ridx_ff    <= 4'h0;
			end else if (st_ff == sap_pkg::ST_REPLY &&
			             (!tx_valid || tx_ready)) begin
				if (ridx_ff != rlen_ff) begin
					tx_data  <= rbuf_ff[ridx_ff];
					tx_valid <= 1'b1;
					ridx_ff  <= ridx_ff + 4'h1;
				end else begin
					tx_valid <= 1'b0;
				end
			end else if (tx_ready) begin
				tx_valid <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// radio-facing outputs
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			radio_lane_number <= sap_pkg::LANE_RST;
			pan_tag           <= sap_pkg::PAN_RST;
			dest_addr         <= {sap_pkg::DEST_RST, sap_pkg::DEST_RST};
			short_addr_mode   <= 1'b1;
			dest_broadcast    <= 1'b0;
			pan_broadcast     <= 1'b0;
			command_mode      <= 1'b0;
		end else begin
			radio_lane_number <= lane_ff;
			pan_tag           <= pan_ff;
			dest_addr         <= {dhi_ff, dlo_ff}; // [RL13]
			short_addr_mode   <= (dhi_ff == 32'h0) &&
			                     (dlo_ff < sap_pkg::SHORT_LIM); // [RL14]
			dest_broadcast    <= (dhi_ff == 32'h0) &&
			                     (dlo_ff == sap_pkg::SHORT_LIM); // [RL15]
			pan_broadcast     <= (pan_ff == sap_pkg::PAN_ALL); // [RL12]
			command_mode      <= (st_ff != sap_pkg::ST_DATA) &&
			                     (st_ff != sap_pkg::ST_ESCG);
		end
	end

	// ---------------------------------------------------------------
	// apb slave
	// ---------------------------------------------------------------
	logic apb_req, apb_fire, apb_hit;
	assign apb_req  = psel && penable && !pready;
	assign apb_fire = psel && penable && pready;
	assign apb_hit  = (paddr == sap_pkg::REG_STATUS) ||
	                  (paddr == sap_pkg::REG_ESC) ||
	                  (paddr == sap_pkg::REG_LANPAN) ||
	                  (paddr == sap_pkg::REG_DHI) ||
	                  (paddr == sap_pkg::REG_DLO);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			esc_ff <= sap_pkg::ESC_RST;
		end else if (apb_fire && pwrite && paddr == sap_pkg::REG_ESC) begin
			esc_ff <= pwdata[7:0]; // [RL16]
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0;
		end else begin
			pready  <= apb_req;
			pslverr <= apb_req && !apb_hit;
			prdata  <= 32'h0;
			if (apb_req && !pwrite) begin
				case (paddr)
					sap_pkg::REG_STATUS: prdata <= {27'h0, rst_pend_ff,
					    pan_broadcast, dest_broadcast, short_addr_mode,
					    command_mode};
					sap_pkg::REG_ESC:    prdata <= {24'h0, esc_ff};
					sap_pkg::REG_LANPAN: prdata <= {8'h0, pan_ff, lane_ff};
					sap_pkg::REG_DHI:    prdata <= dhi_ff;
					sap_pkg::REG_DLO:    prdata <= dlo_ff;
					default:             prdata <= 32'h0;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ### sap_parser_properties.sv
/* sap_chk: port-level properties of the serial command interpreter.
   assumes a single pclk domain with asynchronous active-low presetn. */
`timescale 1ns/10ps
`default_nettype none
module sap_chk (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pready,
	input wire logic        pslverr,
	// serial replies
	input wire logic        tx_valid,
	input wire logic [7:0]  tx_data,
	input wire logic        tx_ready,
	// configuration
	input wire logic [7:0]  radio_lane_number,
	input wire logic [15:0] pan_tag,
	input wire logic [63:0] dest_addr,
	input wire logic        short_addr_mode,
	input wire logic        dest_broadcast,
	input wire logic        pan_broadcast,
	input wire logic        command_mode,
	input wire logic        hard_reset
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_LANE_RANGE: assert property (
		radio_lane_number inside {[8'h0c:8'h17]}) else $error("lane range");
	AST_PAN_ALL: assert property (
		(pan_tag == 16'hffff) [*2] |-> pan_broadcast) else $error("pan all");
	AST_PAN_ONE: assert property (
		(pan_tag != 16'hffff) [*2] |-> !pan_broadcast) else $error("pan one");
	AST_SHORT: assert property (
		(dest_addr[63:32] == 32'h0 && dest_addr[31:0] < 32'hffff) [*2]
		|-> short_addr_mode) else $error("short mode");
	AST_LONG: assert property (
		(dest_addr[63:32] != 32'h0) [*2] |-> !short_addr_mode)
		else $error("long mode");
	AST_BCAST: assert property (
		(dest_addr == 64'hffff) [*2] |-> dest_broadcast) else $error("bcast");
	AST_TX_HOLD: assert property (
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
		else $error("tx byte dropped");
	AST_TX_CMD: assert property (
		tx_valid |-> command_mode) else $error("reply outside command mode");
	AST_ENTER_OK: assert property (
		$rose(command_mode) |-> ##[0:4] tx_valid && tx_data == 8'h4f)
		else $error("no OK on entry");
	AST_RST_PULSE: assert property (
		hard_reset |-> !tx_valid ##1 !hard_reset) else $error("reset pulse");
	AST_APB_ACK: assert property (
		pready |-> psel && penable && $past(psel)) else $error("stray pready");
	AST_APB_ERR: assert property (
		pslverr |-> pready) else $error("stray pslverr");
	cover property (hard_reset);
	cover property (dest_broadcast);
	cover property (pslverr);
endmodule
bind sap_parser sap_chk i_chk (.pclk, .presetn, .psel, .penable, .pready,
	.pslverr, .tx_valid, .tx_data, .tx_ready, .radio_lane_number, .pan_tag,
	.dest_addr, .short_addr_mode, .dest_broadcast, .pan_broadcast,
	.command_mode, .hard_reset);
`default_nettype wire

// ### sap_host.sv
/* sap_host: host terminal model sending text and collecting replies.
   assumes the byte ports of the interpreter, all on pclk. */
`timescale 1ns/10ps
`default_nettype none
module sap_host (
	// clock
	input  wire logic       pclk,
	// serial bytes
	output logic            rx_valid,
	output logic [7:0]      rx_data,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	output logic            tx_ready
);
	logic [7:0] rxq[$];
	logic       slow = 1'b0;
	initial begin
		rx_valid = 1'b0;
		rx_data = 8'h00;
		tx_ready = 1'b0;
	end
	// slow mode stalls every other cycle
	always @(posedge pclk) begin
		if (tx_valid && tx_ready)
			rxq.push_back(tx_data);
		tx_ready <= slow ? !tx_ready : 1'b1;
	end
	// idle data is inverted so a stale byte never looks valid
	task automatic send(input string s);
		foreach (s[i]) begin
			@(posedge pclk);
			rx_valid <= 1'b1;
			rx_data <= s[i];
			@(posedge pclk);
			rx_valid <= 1'b0;
			rx_data <= ~s[i];
		end
	endtask
endmodule
`default_nettype wire

// ### tb.sv
/* tb: runs the command interpreter over its serial and apb ports.
   assumes the sap_host model and the bound sap_chk checker. */
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic        pready, pslverr, rx_valid, tx_valid, tx_ready, e;
	logic [31:0] prdata, q;
	logic [7:0]  rx_data, tx_data, radio_lane_number;
	logic [15:0] pan_tag;
	logic [63:0] dest_addr;
	logic        short_addr_mode, dest_broadcast, pan_broadcast;
	logic        command_mode, hard_reset;
	int          n_mismatch = 0;
	int          n_checks = 0;
	string       esc = "+++";

	sap_parser #(.GUARD_CYCLES(32'h14), .TIMEOUT_CYCLES(32'hc8),
		.RESET_CYCLES(32'ha)) i_dut (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .rx_valid,
		.rx_data, .tx_valid, .tx_data, .tx_ready, .radio_lane_number,
		.pan_tag, .dest_addr, .short_addr_mode, .dest_broadcast,
		.pan_broadcast, .command_mode, .hard_reset);
	sap_host i_host (.pclk, .rx_valid, .rx_data, .tx_valid, .tx_data,
		.tx_ready);

	initial forever #5 pclk = ~pclk;
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			n_mismatch++;
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic expect_reply(input string r);
		int n;
		n = 0;
		while (i_host.rxq.size() < r.len() && n < 2000) begin
			@(posedge pclk);
			n++;
		end
		repeat (4) @(posedge pclk);
		chk(i_host.rxq.size(), r.len());
		foreach (r[i]) if (i < i_host.rxq.size()) chk(i_host.rxq[i], r[i]);
		i_host.rxq.delete();
	endtask
	task automatic cmd(input string s, input string r);
		i_host.send(s);
		expect_reply(r);
	endtask
	task automatic enter();
		repeat (25) @(posedge pclk);
		cmd(esc, "OK\r");
	endtask
	task automatic report_and_stop();
		if (n_mismatch == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_read();
		enter();
		chk(command_mode, 1'b1);
		cmd("ATDL\r", "0\r");
		cmd("ATCH\r", "C\r");
		cmd("ATID\r", "3332\r");
	endtask
	task automatic t_multi();
		cmd("ATDL1A0D,", "OK\r");
		cmd("WR,", "OK\r");
		cmd("\103N\r", "OK\r");
		chk(dest_addr, 64'h1a0d);
		chk(command_mode, 1'b0);
		cmd("ATDL\r", "");
	endtask
	task automatic t_apb();
		apb(1'b0, 8'h08, 32'h0);
		chk(q, 32'h0033320c);
		apb(1'b1, 8'h00, 32'hff);
		chk(e, 1'b0);
		apb(1'b0, 8'h00, 32'h0);
		chk(q, 32'h2);
		apb(1'b0, 8'h20, 32'h0);
		chk({e, q}, 33'h100000000);
		apb(1'b0, 8'h04, 32'h0);
		chk(q, 32'h2b);
		apb(1'b1, 8'h04, 32'h2a);
		apb(1'b0, 8'h04, 32'h0);
		chk(q, 32'h2a);
		esc = "***";
	endtask
	task automatic t_range();
		i_host.slow = 1'b1;
		enter();
		cmd("ATCH18\r", "ERROR\r");
		cmd("ATCHB\r", "ERROR\r");
		chk(radio_lane_number, 8'h0c);
		cmd("ATCH17\r", "OK\r");
		chk(radio_lane_number, 8'h17);
		cmd("ATIDFFFF\r", "OK\r");
		chk(pan_broadcast, 1'b1);
		cmd("ATDLFFFF\r", "OK\r");
		chk({short_addr_mode, dest_broadcast}, 2'h1);
		cmd("ATDH1\r", "OK\r");
		chk(dest_addr, 64'h10000ffff);
		cmd("ATWR5\r", "ERROR\r");
		cmd("ATRE\r", "OK\r");
		chk({radio_lane_number, pan_tag}, 24'h0c3332);
		chk({dest_addr, short_addr_mode}, 65'h1);
		i_host.slow = 1'b0;
	endtask
	task automatic t_timeout();
		chk(command_mode, 1'b1);
		repeat (250) @(posedge pclk);
		chk(command_mode, 1'b0);
	endtask
	task automatic t_reset();
		int n;
		enter();
		cmd("ATCH15\r", "OK\r");
		cmd("ATFR\r", "OK\r");
		n = 0;
		while (hard_reset !== 1'b1 && n < 100) begin
			@(posedge pclk);
			n++;
		end
		chk(hard_reset, 1'b1);
		repeat (3) @(posedge pclk);
		chk(radio_lane_number, 8'h0c);
		chk(dest_addr, 64'h1a0d);
		chk(command_mode, 1'b0);
	endtask

	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		t_read();
		t_multi();
		t_apb();
		t_range();
		t_timeout();
		t_reset();
		report_and_stop();
	end
	initial begin
		repeat (20000) @(posedge pclk);
		n_mismatch++;
		report_and_stop();
	end
endmodule
`default_nettype wire
